// ==== hdl/pief_top.sv ====
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module pief_top (
	input  wire logic                             sys_clk,         // System clock
	input  wire logic                             rst,             // Sync reset
	// Wishbone classic slave
	input  wire logic                             wb_cyc_i,        // Cycle
	input  wire logic                             wb_stb_i,        // Strobe
	input  wire logic                             wb_we_i,         // Write
	input  wire logic [7:0]                       wb_adr_i,        // Byte address
	input  wire logic [3:0]                       wb_sel_i,        // Byte lanes
	input  wire logic [31:0]                      wb_dat_i,        // Write data
	output logic      [31:0]                      wb_dat_o,        // Read data
	output logic                                  wb_ack_o,        // Acknowledge
	// Peripheral events, same clock except the async pins
	input  wire logic [7:0]                       timerACount,     // Timer A count
	input  wire logic                             serialOneDone,   // Transfer done
	input  wire logic [pief_pkg::EXT_PIN_COUNT-1:0] extRequestPin, // Async pins
	input  wire logic [pief_pkg::EXT_PIN_COUNT-1:0] extPinIrqMode, // Pin is irq
	input  wire logic [pief_pkg::EXT_PIN_COUNT-1:0] extPinRising,  // 1 rise 0 fall
	input  wire logic                             sleepExecuted,   // Sleep pulse
	input  wire logic                             directTransferOn, // Transfer bit
	input  wire logic                             conversionStartFlag, // ADC busy
	input  wire logic                             timerGCapture,   // Capture pulse
	input  wire logic                             timerGOverflow,  // Overflow pulse
	input  wire logic [7:0]                       timerCCount,     // Timer C count
	input  wire logic [7:0]                       timerFLowCounter, // Low count
	input  wire logic [7:0]                       timerFLowCompare, // Low compare
	input  wire logic [7:0]                       timerFHighCounter, // High count
	input  wire logic [7:0]                       timerFHighCompare, // High compare
	input  wire logic                             timerF16Mode,    // 16-bit mode
	input  wire logic                             eventCounterHighOvf, // High ovf
	input  wire logic                             eventCounterLowOvf,  // Low ovf
	input  wire logic                             eventCounter16Mode,  // 16-bit
	input  wire logic [7:0]                       irqEnableOne,    // First enables
	// Requests toward the core
	output logic      [7:0]                       irqReqOne,       // Flags-one reqs
	output logic      [7:0]                       irqReqTwo        // Flags-two reqs
);
	import pief_pkg::*;

	// Register state
	logic [7:0]      enableTwo_r;     // Enable register two
	logic [7:0]      flagsOne_r;      // Flags register one, bit 5 unused
	logic [7:0]      flagsTwo_r;      // Flags register two
	pief_bus_e       busState_r;      // Slave state
	pief_bus_e       busState_nxt;    // Next slave state

	// Event history
	logic [7:0]      timerAPrev_r;    // Timer A count last cycle
	logic [7:0]      timerCPrev_r;    // Timer C count last cycle
	logic            convBusyPrev_r;  // Converter busy last cycle
	logic            lowMatchPrev_r;  // Low match last cycle
	logic            highMatchPrev_r; // High match last cycle, full match in 16-bit mode
	logic            primed_r;        // History valid after reset

	// Pin synchroniser stages
	logic [EXT_PIN_COUNT-1:0] pinMeta_r;  // First stage
	logic [EXT_PIN_COUNT-1:0] pinSync_r;  // Second stage
	logic [EXT_PIN_COUNT-1:0] pinPrev_r;  // Edge history
	logic [1:0]               pinWarm_r;  // Stages filled since reset

	// Decoded access
	logic            busReq;          // Fresh request seen
	logic            wrLane0;         // Write hits low byte
	logic            hitEnable;       // Enable register selected
	logic            hitOne;          // Flags one selected
	logic            hitTwo;          // Flags two selected
	logic [7:0]      readByte;        // Read mux result

	// Set events
	logic [7:0]      setOne;          // Sets for flags one
	logic [7:0]      setTwo;          // Sets for flags two
	logic [7:0]      clrOne;          // Clears for flags one
	logic [7:0]      clrTwo;          // Clears for flags two
	logic            lowMatch;        // Low counter equals compare
	logic            highMatch;       // High counter equals compare
	logic            fullMatch;       // Both halves equal
	logic [EXT_PIN_COUNT-1:0] pinEdge; // Selected edge arrived

	// Request only in idle, so a held strobe is served every second cycle
	assign busReq    = wb_cyc_i & wb_stb_i & (busState_r == BUS_IDLE);
	assign wrLane0   = busReq & wb_we_i & wb_sel_i[0];
	assign hitEnable = (wb_adr_i == ENABLE_TWO_OFS);
	assign hitOne    = (wb_adr_i == FLAGS_ONE_OFS);
	assign hitTwo    = (wb_adr_i == FLAGS_TWO_OFS);

	// Read mux; unmapped addresses read zero
	always_comb begin
		readByte = 8'h00;
		if (hitEnable) begin
			readByte = enableTwo_r;
		end else if (hitOne) begin
			// Fixed bit always reads one
			readByte = flagsOne_r | (8'h01 << FLAGS_ONE_FIXED);
		end else if (hitTwo) begin
			readByte = flagsTwo_r;
		end
	end

	// Slave state machine: one ack per request
	always_comb begin
		busState_nxt = busState_r;
		unique case (busState_r)
			BUS_IDLE: begin
				if (busReq) begin
					busState_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				// Ack stands one cycle, master releases after it
				busState_nxt = BUS_IDLE;
			end
			default: begin
				busState_nxt = BUS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busState_r <= BUS_IDLE;
		end else begin
			busState_r <= busState_nxt;
		end
	end

	// Ack and read data, both registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busReq;
			if (busReq && !wb_we_i) begin
				wb_dat_o <= {24'h00_0000, readByte};
			end
		end
	end

	// Enable register two, all bits plain storage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			enableTwo_r <= ENABLE_TWO_RST;
		end else if (wrLane0 && hitEnable) begin
			// Writing enables never touches flags
			enableTwo_r <= wb_dat_i[7:0];
		end
	end

	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			pinPrev_r <= '0;
			pinWarm_r <= 2'h0;
		end else begin
			pinMeta_r <= extRequestPin;
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r;
			// Count up until the history holds real pin samples
			if (pinWarm_r != 2'h3) begin
				pinWarm_r <= pinWarm_r + 2'h1;
			end
		end
	end

	// Edge of chosen polarity on pins set up for interrupts;
	// held off while the stages fill, else an idle-high pin
	// would look like a rising edge right after reset
	assign pinEdge = {EXT_PIN_COUNT{&pinWarm_r}} & extPinIrqMode
		& ((extPinRising & pinSync_r & ~pinPrev_r)
		| (~extPinRising & ~pinSync_r & pinPrev_r));

	// Peripheral history, to find wraps and new matches
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timerAPrev_r    <= COUNT_ZERO;
			timerCPrev_r    <= COUNT_ZERO;
			convBusyPrev_r  <= 1'b0;
			lowMatchPrev_r  <= 1'b0;
			highMatchPrev_r <= 1'b0;
			primed_r        <= 1'b0;
		end else begin
			timerAPrev_r    <= timerACount;
			timerCPrev_r    <= timerCCount;
			convBusyPrev_r  <= conversionStartFlag;
			lowMatchPrev_r  <= lowMatch;
			highMatchPrev_r <= timerF16Mode ? fullMatch : highMatch;
			primed_r        <= 1'b1;
		end
	end

	// Compare results; a match holds while the count dwells,
	// so only its rising edge counts as an event
	assign lowMatch  = (timerFLowCounter == timerFLowCompare);
	assign highMatch = (timerFHighCounter == timerFHighCompare);
	assign fullMatch = lowMatch & highMatch;

	// Set terms for flags one
	always_comb begin
		setOne = 8'h00;
		// Wrap from top to zero
		setOne[TIMER_A_OVERFLOW_FLAG] = primed_r
			& (timerAPrev_r == COUNT_MAX) & (timerACount == COUNT_ZERO);
		setOne[SERIAL_ONE_DONE_FLAG] = serialOneDone;
		setOne[EXT_PIN_COUNT-1:0] = pinEdge;
	end

	// Set terms for flags two
	always_comb begin
		setTwo = 8'h00;
		setTwo[DIRECT_XFER_FLAG] = sleepExecuted & directTransferOn;
		// Busy flag falling marks conversion end
		setTwo[ADC_DONE_FLAG] = convBusyPrev_r & ~conversionStartFlag;
		setTwo[TIMER_G_FLAG] = timerGCapture | timerGOverflow;
		// Overflow up or underflow down
		setTwo[TIMER_C_FLAG] = primed_r
			& (((timerCPrev_r == COUNT_MAX) & (timerCCount == COUNT_ZERO))
			| ((timerCPrev_r == COUNT_ZERO) & (timerCCount == COUNT_MAX)));
		// Low half only counts in 8-bit mode
		setTwo[TIMER_F_LOW_FLAG] = primed_r & ~timerF16Mode
			& lowMatch & ~lowMatchPrev_r;
		setTwo[TIMER_F_HIGH_FLAG] = primed_r & (timerF16Mode
			? (fullMatch & ~highMatchPrev_r)
			: (highMatch & ~highMatchPrev_r));
		setTwo[EVENT_COUNTER_FLAG] = eventCounterHighOvf
			| (~eventCounter16Mode & eventCounterLowOvf);
	end

	// Clears: a zero written clears, a one leaves the flag alone
	always_comb begin
		clrOne = 8'h00;
		clrTwo = 8'h00;
		if (wrLane0 && hitOne) begin
			clrOne = ~wb_dat_i[7:0];
		end
		if (wrLane0 && hitTwo) begin
			clrTwo = ~wb_dat_i[7:0];
		end
	end

	// Flags one; set beats a clear in the same cycle, and
	// acceptance by the core never clears anything
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flagsOne_r <= FLAGS_ONE_RST & ~(8'h01 << FLAGS_ONE_FIXED);
		end else begin
			flagsOne_r <= ((flagsOne_r & ~clrOne) | setOne)
				& ~(8'h01 << FLAGS_ONE_FIXED);
		end
	end

	// Flags two; reserved bit behaves as plain storage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flagsTwo_r <= FLAGS_TWO_RST;
		end else begin
			flagsTwo_r[FLAGS_TWO_RESERVED] <= (wrLane0 && hitTwo)
				? wb_dat_i[FLAGS_TWO_RESERVED]
				: flagsTwo_r[FLAGS_TWO_RESERVED];
			flagsTwo_r[7:6] <= (flagsTwo_r[7:6] & ~clrTwo[7:6])
				| setTwo[7:6];
			flagsTwo_r[4:0] <= (flagsTwo_r[4:0] & ~clrTwo[4:0])
				| setTwo[4:0];
		end
	end

	// Requests toward the core, flag and enable both needed;
	// one cycle behind the flag, since outputs are registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irqReqOne <= 8'h00;
			irqReqTwo <= 8'h00;
		end else begin
			irqReqOne <= flagsOne_r & irqEnableOne;
			irqReqTwo[DIRECT_XFER_FLAG] <= flagsTwo_r[DIRECT_XFER_FLAG]
				& enableTwo_r[DIRECT_XFER_IRQ_EN];
			irqReqTwo[ADC_DONE_FLAG] <= flagsTwo_r[ADC_DONE_FLAG]
				& enableTwo_r[ADC_DONE_IRQ_EN];
			// Reserved pair never requests
			irqReqTwo[FLAGS_TWO_RESERVED] <= 1'b0;
			irqReqTwo[TIMER_G_FLAG] <= flagsTwo_r[TIMER_G_FLAG]
				& enableTwo_r[TIMER_G_IRQ_EN];
			irqReqTwo[TIMER_F_HIGH_FLAG] <= flagsTwo_r[TIMER_F_HIGH_FLAG]
				& enableTwo_r[TIMER_F_HIGH_IRQ_EN];
			irqReqTwo[TIMER_F_LOW_FLAG] <= flagsTwo_r[TIMER_F_LOW_FLAG]
				& enableTwo_r[TIMER_F_LOW_IRQ_EN];
			irqReqTwo[TIMER_C_FLAG] <= flagsTwo_r[TIMER_C_FLAG]
				& enableTwo_r[TIMER_C_IRQ_EN];
			irqReqTwo[EVENT_COUNTER_FLAG] <= flagsTwo_r[EVENT_COUNTER_FLAG]
				& enableTwo_r[EVENT_COUNTER_IRQ_EN];
		end
	end

endmodule

// ==== hdl/pief_pkg.sv ====
// Behaviour
// - Enable register two, 8-bit RW, resets zero
// - Enable bit 7 gates direct transfer
// - Enable bit 6 gates converter done
// - Enable bit 5 reserved RW, resets zero
// - Enable bit 4 gates timer G
// - Enable bit 3 gates timer F high
// - Enable bit 2 gates timer F low
// - Enable bit 1 gates timer C
// - Enable bit 0 gates event counter
// - Flags stay set when interrupt accepted
// - Writing zero clears flag; one ignored
// - Timer A wrap sets flags-one bit 7
// - Serial one done sets flags-one bit 6
// - Flags-one bit 5 reads one always
// - Selected pin edge sets flags-one bits 4-0
// - Sleep with direct transfer sets bit 7
// - Conversion end sets flags-two bit 6
// - Timer C wrap either way sets flag
// - Low match in 8-bit mode sets flag
// - High or full match sets high flag
// - Event counter overflow sets its flag
package pief_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] ENABLE_TWO_OFS = 8'h00;
	localparam logic [7:0] FLAGS_ONE_OFS  = 8'h04;
	localparam logic [7:0] FLAGS_TWO_OFS  = 8'h08;

	// Reset values
	localparam logic [7:0] ENABLE_TWO_RST = 8'h00;
	localparam logic [7:0] FLAGS_ONE_RST  = 8'h20;
	localparam logic [7:0] FLAGS_TWO_RST  = 8'h00;

	// Enable register two fields
	localparam int DIRECT_XFER_IRQ_EN   = 7;
	localparam int ADC_DONE_IRQ_EN      = 6;
	localparam int ENABLE_RESERVED      = 5;
	localparam int TIMER_G_IRQ_EN       = 4;
	localparam int TIMER_F_HIGH_IRQ_EN  = 3;
	localparam int TIMER_F_LOW_IRQ_EN   = 2;
	localparam int TIMER_C_IRQ_EN       = 1;
	localparam int EVENT_COUNTER_IRQ_EN = 0;

	// Flags register one fields
	localparam int TIMER_A_OVERFLOW_FLAG = 7;
	localparam int SERIAL_ONE_DONE_FLAG  = 6;
	localparam int FLAGS_ONE_FIXED       = 5;
	localparam int EXT_PIN_COUNT         = 5;

	// Flags register two fields
	localparam int DIRECT_XFER_FLAG   = 7;
	localparam int ADC_DONE_FLAG      = 6;
	localparam int FLAGS_TWO_RESERVED = 5;
	localparam int TIMER_G_FLAG       = 4;
	localparam int TIMER_F_HIGH_FLAG  = 3;
	localparam int TIMER_F_LOW_FLAG   = 2;
	localparam int TIMER_C_FLAG       = 1;
	localparam int EVENT_COUNTER_FLAG = 0;

	// Counter end values for wrap detection
	localparam logic [7:0] COUNT_MAX  = 8'hff;
	localparam logic [7:0] COUNT_ZERO = 8'h00;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} pief_bus_e;

endpackage

// ==== tb/pief_props.sv ====
`timescale 1ns/10ps
module pief_props (
	input wire logic        sys_clk,       // Clock
	input wire logic        rst,           // Sync reset
	input wire logic        wb_cyc_i,      // Cycle
	input wire logic        wb_stb_i,      // Strobe
	input wire logic        wb_we_i,       // Write
	input wire logic [31:0] wb_dat_o,      // Read data
	input wire logic        wb_ack_o,      // Acknowledge
	input wire logic [7:0]  timerACount,   // Timer A count
	input wire logic        serialOneDone, // Transfer done
	input wire logic [7:0]  irqEnableOne,  // First enables
	input wire logic [7:0]  irqReqOne,     // Flags-one reqs
	input wire logic [7:0]  irqReqTwo      // Flags-two reqs
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Request seen while slave idle
	wire takeReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Any write on the bus; wider than needed, only narrows checks
	wire wrReq = wb_cyc_i && wb_stb_i && wb_we_i;
	// Counter passes from top to zero with its enable on
	sequence wrapA;
		timerACount == 8'hff ##1 timerACount == 8'h00 && irqEnableOne[7];
	endsequence
	// Transfer end seen with its enable on
	sequence doneOne;
		serialOneDone && irqEnableOne[6];
	endsequence
	a_ack_after_take: assert property (takeReq |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_dat_hold: assert property (!(takeReq && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data moved without a read");
	a_req_gated: assert property ((irqReqOne & ~$past(irqEnableOne)) == 8'h00)
		else $error("request without enable");
	a_reserved_low: assert property (!irqReqOne[5] && !irqReqTwo[5])
		else $error("request on reserved bit");
	a_flag_sticky: assert property (irqReqOne[6] && irqEnableOne[6]
		&& !$past(wrReq) |=> irqReqOne[6])
		else $error("flag dropped without a clear");
	a_serial_sets: assert property (doneOne ##1 irqEnableOne[6] |=> irqReqOne[6])
		else $error("transfer end gave no request");
	a_wrap_sets: assert property (wrapA ##1 irqEnableOne[7] |=> irqReqOne[7])
		else $error("timer wrap gave no request");
endmodule

bind pief_top pief_props u_pief_props (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_dat_o, .wb_ack_o, .timerACount, .serialOneDone,
	.irqEnableOne, .irqReqOne, .irqReqTwo);

// ==== tb/pief_core_model.sv ====
`timescale 1ns/10ps
module pief_core_model (
	input  wire logic       sys_clk,      // Clock
	input  wire logic       rst,          // Sync reset
	input  wire logic [7:0] irqReqOne,    // Requests one
	input  wire logic [7:0] irqReqTwo,    // Requests two
	output logic      [7:0] acceptCount_r // Requests taken
);
	// Core takes any pending request but never touches a flag;
	// the handler must clear it over the bus, so flags stay up
	always_ff @(posedge sys_clk) begin
		if (rst)
			acceptCount_r <= 8'h00;
		else if ((irqReqOne | irqReqTwo) != 8'h00 && acceptCount_r != 8'hff)
			acceptCount_r <= acceptCount_r + 8'h01;
	end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
	import pief_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, serialOneDone = 1'b0;
	logic sleepExecuted = 1'b0, directTransferOn = 1'b0;
	logic conversionStartFlag = 1'b0, timerGCapture = 1'b0;
	logic timerGOverflow = 1'b0, timerF16Mode = 1'b0;
	logic eventCounterHighOvf = 1'b0, eventCounterLowOvf = 1'b0;
	logic eventCounter16Mode = 1'b0;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [7:0] wb_adr_i = 8'h00, timerACount = 8'h00, timerCCount = 8'h00;
	logic [7:0] timerFLowCounter = 8'h00, timerFLowCompare = 8'h33;
	logic [7:0] timerFHighCounter = 8'h00, timerFHighCompare = 8'h33;
	logic [7:0] irqEnableOne = 8'hff, irqReqOne, irqReqTwo, acceptCount, m;
	logic [EXT_PIN_COUNT-1:0] extRequestPin = 5'h00;
	logic [EXT_PIN_COUNT-1:0] extPinIrqMode = 5'h1f, extPinRising = 5'h1f;
	int numErrors = 0, testsRun = 0, cycles = 0;
	int src[7] = '{7, 6, 4, 3, 2, 1, 0};

	pief_top u_pief_top (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timerACount,
		.serialOneDone, .extRequestPin, .extPinIrqMode, .extPinRising,
		.sleepExecuted, .directTransferOn, .conversionStartFlag,
		.timerGCapture, .timerGOverflow, .timerCCount, .timerFLowCounter,
		.timerFLowCompare, .timerFHighCounter, .timerFHighCompare,
		.timerF16Mode, .eventCounterHighOvf, .eventCounterLowOvf,
		.eventCounter16Mode, .irqEnableOne, .irqReqOne, .irqReqTwo);
	pief_core_model u_pief_core_model (.sys_clk, .rst, .irqReqOne,
		.irqReqTwo, .acceptCount_r(acceptCount));

	// Free running clock
	always #5 sys_clk = ~sys_clk;
	// Hang guard, well above the few hundred cycles used
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			closeOut;
		end
	end

	task automatic closeOut;
		if (numErrors == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One classic cycle; waits on ack, giving up after 50 cycles
	task automatic bus(input logic we, input logic [7:0] a, d,
		output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		chk({31'h0, wb_ack_o}, 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	// One event of the source behind flags-two bit i
	task automatic fire(input int i);
		@(posedge sys_clk);
		case (i)
			7: sleepExecuted <= 1'b1;
			6: conversionStartFlag <= 1'b1;
			4: timerGCapture <= 1'b1;
			3: timerFHighCounter <= 8'h5a;
			2: timerFLowCounter <= 8'h5a;
			1: timerCCount <= 8'hff;
			default: eventCounterLowOvf <= 1'b1;
		endcase
		timerFHighCompare <= 8'h5a;
		timerFLowCompare <= 8'h5a;
		directTransferOn <= 1'b1;
		@(posedge sys_clk);
		sleepExecuted <= 1'b0;
		conversionStartFlag <= 1'b0;
		timerGCapture <= 1'b0;
		eventCounterLowOvf <= 1'b0;
		timerFHighCounter <= 8'h00;
		timerFLowCounter <= 8'h00;
	endtask

	initial begin
		tick(10);
		rst <= 1'b0;
		tick(2);
		rd(ENABLE_TWO_OFS, 8'h00);
		rd(FLAGS_ONE_OFS, 8'h20);
		rd(FLAGS_TWO_OFS, 8'h00);
		rd(8'h0c, 8'h00);
		wb_sel_i <= 4'h0;
		wr(ENABLE_TWO_OFS, 8'hff);
		rd(ENABLE_TWO_OFS, 8'h00);
		wb_sel_i <= 4'h1;
		wr(ENABLE_TWO_OFS, 8'hff);
		rd(ENABLE_TWO_OFS, 8'hff);
		wr(ENABLE_TWO_OFS, 8'h00);
		wr(FLAGS_TWO_OFS, 8'h20);
		rd(FLAGS_TWO_OFS, 8'h20);
		wr(FLAGS_TWO_OFS, 8'h00);
		// Each flags-two source: blocked, passed, kept, cleared
		for (int k = 0; k < 7; k++) begin
			m = 8'h01 << src[k];
			fire(src[k]);
			tick(3);
			chk({24'h0, irqReqTwo}, 32'h0);
			rd(FLAGS_TWO_OFS, m);
			wr(ENABLE_TWO_OFS, m);
			tick(2);
			chk({24'h0, irqReqTwo}, {24'h0, m});
			wr(FLAGS_TWO_OFS, 8'hdf);
			rd(FLAGS_TWO_OFS, m);
			wr(FLAGS_TWO_OFS, 8'h00);
			tick(2);
			chk({24'h0, irqReqTwo}, 32'h0);
			wr(ENABLE_TWO_OFS, 8'h00);
		end
		// 16-bit modes: low halves alone set nothing
		timerF16Mode <= 1'b1;
		eventCounter16Mode <= 1'b1;
		fire(2);
		fire(0);
		tick(1);
		// Sleep with direct transfer off sets nothing
		directTransferOn <= 1'b0;
		sleepExecuted <= 1'b1;
		tick(1);
		sleepExecuted <= 1'b0;
		tick(3);
		rd(FLAGS_TWO_OFS, 8'h00);
		// Full match, high overflow, timer G overflow, timer C upward wrap
		timerFLowCounter <= 8'h5a;
		timerFHighCounter <= 8'h5a;
		eventCounterHighOvf <= 1'b1;
		timerGOverflow <= 1'b1;
		timerCCount <= 8'h00;
		tick(1);
		eventCounterHighOvf <= 1'b0;
		timerGOverflow <= 1'b0;
		timerFLowCounter <= 8'h00;
		timerFHighCounter <= 8'h00;
		tick(3);
		rd(FLAGS_TWO_OFS, 8'h1b);
		wr(FLAGS_TWO_OFS, 8'h00);
		timerF16Mode <= 1'b0;
		eventCounter16Mode <= 1'b0;
		// Flags-one sources, rising then falling pin edges
		timerACount <= 8'hff;
		tick(1);
		timerACount <= 8'h00;
		serialOneDone <= 1'b1;
		extRequestPin <= 5'h1f;
		tick(1);
		serialOneDone <= 1'b0;
		tick(6);
		chk({24'h0, irqReqOne}, 32'hdf);
		// First enables gate the flags-one requests
		irqEnableOne <= 8'h40;
		tick(2);
		chk({24'h0, irqReqOne}, 32'h40);
		irqEnableOne <= 8'hff;
		rd(FLAGS_ONE_OFS, 8'hff);
		tick(4);
		chk({31'h0, acceptCount != 8'h00}, 32'h1);
		rd(FLAGS_ONE_OFS, 8'hff);
		wr(FLAGS_ONE_OFS, 8'h00);
		rd(FLAGS_ONE_OFS, 8'h20);
		extPinRising <= 5'h00;
		extRequestPin <= 5'h00;
		tick(6);
		rd(FLAGS_ONE_OFS, 8'h3f);
		// Pins not set up for interrupts are ignored
		wr(FLAGS_ONE_OFS, 8'h00);
		extPinIrqMode <= 5'h00;
		extPinRising <= 5'h1f;
		extRequestPin <= 5'h1f;
		tick(6);
		rd(FLAGS_ONE_OFS, 8'h20);
		closeOut;
	end
endmodule
